// *** design/ctb_consts.svh ***
`ifndef CTB_CONSTS_SVH
`define CTB_CONSTS_SVH
`define CTB_ADDR_RSP_TO     8'h00
`define CTB_ADDR_DATA_TO    8'h04
`define CTB_ADDR_BLK_LEN    8'h08
`define CTB_ADDR_BLK_CNT    8'h0C
`define CTB_ADDR_BLK_REM    8'h10
`define CTB_ADDR_STATUS     8'h14
`define CTB_ADDR_MASK       8'h18
`define CTB_ADDR_CTRL       8'h1C
`define CTB_BIT_RSP_TO      4
`define CTB_BIT_DATA_TO     3
`define CTB_BIT_DONE        0
`define CTB_CTRL_RSP_START  0
`define CTB_CTRL_RSP_ARRIVE 1
`define CTB_CTRL_XFER_START 2
`define CTB_CTRL_BLK_DONE   3
`define CTB_CTRL_STOP       4
`define CTB_CTRL_DATA_START 5
`define CTB_CTRL_DATA_ARR   6
`define CTB_BLK_LEN_RESET   12'h200
`define CTB_STATUS_W        5
`endif

// *** design/ctb_pkg.sv ***
package ctb_pkg;
	typedef enum logic [1:0] {CTB_IDLE, CTB_XFER} ctb_xfer_t;
	typedef logic [20:0] ctb_count_t;
endpackage

// *** design/ctb_timeout_block_count.sv ***
// Behaviour
// RULE1 - Count clocks while awaiting a response; flag response time-out on expiry.
// RULE2 - A set response time-out flag with its enable raises the interrupt.
// RULE3 - Response limit zero disables; 1 to 255 gives that many clocks.
// RULE4 - Data limit is 21 bits: five upper from response register, sixteen lower.
// RULE5 - Data limit zero disables; otherwise one to 2097151 clocks.
// RULE6 - Waiting for read data, flag data time-out on expiry; interrupt if enabled.
// RULE7 - Twelve-bit block length, reset 200h, zero prohibited.
// RULE8 - Software matches block length to the card's configured block size.
// RULE9 - Block total zero transfers blocks until a stop command.
// RULE10 - Block total n transfers exactly n blocks, then stops.
// RULE11 - Sixteen-bit readable down-counter of blocks still to move.
// RULE12 - Software uses its own timer for waits beyond hardware limits.
// RULE13 - Interrupt only on a flag rising while its mask bit is one.
// RULE14 - Remaining count loads at transfer start and drops per completed block; the code leaves it unchanged when the block total is zero.
// RULE15 - Time-out counters restart on a new wait and stop on arrival.
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "ctb_consts.svh"
module ctb_timeout_block_count (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq_o,
	output logic             xfer_active_o
);
	import ctb_pkg::*;

	logic [7:0]  response_limit_reg;
	logic [4:0]  data_limit_upper_reg;
	logic [15:0] data_limit_lower_reg;
	logic [11:0] bytes_per_block_reg;
	logic [15:0] block_total_reg;
	logic [15:0] block_remaining_count_reg;
	logic [`CTB_STATUS_W-1:0] primary_status_reg;
	logic [`CTB_STATUS_W-1:0] primary_status_next;
	logic [`CTB_STATUS_W-1:0] interrupt_enable_mask_reg;
	logic        rsp_wait_reg;
	logic        data_wait_reg;
	logic [7:0]  rsp_cnt_reg;
	ctb_count_t  data_cnt_reg;
	ctb_xfer_t   xfer_state_reg;
	logic [31:0] rd_mux;
	logic        irq_pend_reg;

	wire access    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr        = access && wb_we_i;
	wire rd        = access && !wb_we_i;
	wire sel_rto   = wb_adr_i == `CTB_ADDR_RSP_TO;
	wire sel_dto   = wb_adr_i == `CTB_ADDR_DATA_TO;
	wire sel_len   = wb_adr_i == `CTB_ADDR_BLK_LEN;
	wire sel_cnt   = wb_adr_i == `CTB_ADDR_BLK_CNT;
	wire sel_rem   = wb_adr_i == `CTB_ADDR_BLK_REM;
	wire sel_st    = wb_adr_i == `CTB_ADDR_STATUS;
	wire sel_msk   = wb_adr_i == `CTB_ADDR_MASK;
	wire sel_ctl   = wb_adr_i == `CTB_ADDR_CTRL;
	wire ctl_wr    = wr && sel_ctl && wb_sel_i[0];
	wire rsp_start = ctl_wr && wb_dat_i[`CTB_CTRL_RSP_START];
	wire rsp_arr   = ctl_wr && wb_dat_i[`CTB_CTRL_RSP_ARRIVE];
	wire x_start   = ctl_wr && wb_dat_i[`CTB_CTRL_XFER_START];
	wire blk_done  = ctl_wr && wb_dat_i[`CTB_CTRL_BLK_DONE];
	wire stop_cmd  = ctl_wr && wb_dat_i[`CTB_CTRL_STOP];
	wire d_start   = ctl_wr && wb_dat_i[`CTB_CTRL_DATA_START];
	wire d_arr     = ctl_wr && wb_dat_i[`CTB_CTRL_DATA_ARR];
	wire [20:0] data_limit = {data_limit_upper_reg, data_limit_lower_reg}; // see RULE4
	// Zero limits disable the timers; the wait still ends on arrival.
	wire rsp_expire = rsp_wait_reg && response_limit_reg != 8'h00
		&& rsp_cnt_reg == response_limit_reg - 8'h01; // see RULE3
	wire data_expire = data_wait_reg && data_limit != 21'h000000
		&& data_cnt_reg == data_limit - 21'h000001; // see RULE5
	wire in_xfer = xfer_state_reg == CTB_XFER;
	wire last_blk = blk_done && in_xfer && block_total_reg != 16'h0000
		&& block_remaining_count_reg == 16'h0001; // see RULE10
	wire [`CTB_STATUS_W-1:0] events;
	assign events[`CTB_BIT_RSP_TO]  = rsp_expire;
	assign events[`CTB_BIT_DATA_TO] = data_expire;
	assign events[2]                = 1'b0;
	assign events[1]                = 1'b0;
	assign events[`CTB_BIT_DONE]    = last_blk || (in_xfer && stop_cmd);
	wire st_rd = rd && sel_st;

	// Set beats the read-clear so an event in the clearing cycle survives.
	assign primary_status_next = (st_rd ? '0 : primary_status_reg) | events;
	wire [`CTB_STATUS_W-1:0] rising = events & ~primary_status_reg;

	assign rd_mux = sel_rto ? {19'h0, data_limit_upper_reg, response_limit_reg} :
		sel_dto ? {16'h0, data_limit_lower_reg} :
		sel_len ? {20'h0, bytes_per_block_reg} :
		sel_cnt ? {16'h0, block_total_reg} :
		sel_rem ? {16'h0, block_remaining_count_reg} : // see RULE11
		sel_st  ? {27'h0, primary_status_reg} :
		sel_msk ? {27'h0, interrupt_enable_mask_reg} :
		sel_ctl ? {31'h0, in_xfer} : 32'h0;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= access;
			wb_dat_o <= rd ? rd_mux : 32'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			response_limit_reg   <= 8'h00;
			data_limit_upper_reg <= 5'h00;
			data_limit_lower_reg <= 16'h0000;
			bytes_per_block_reg  <= `CTB_BLK_LEN_RESET; // see RULE7
			block_total_reg      <= 16'h0000;
			interrupt_enable_mask_reg <= '0;
		end else if (wr) begin
			if (sel_rto && wb_sel_i[0])
				response_limit_reg <= wb_dat_i[7:0];
			if (sel_rto && wb_sel_i[1])
				data_limit_upper_reg <= wb_dat_i[12:8];
			if (sel_dto && wb_sel_i[0])
				data_limit_lower_reg[7:0] <= wb_dat_i[7:0];
			if (sel_dto && wb_sel_i[1])
				data_limit_lower_reg[15:8] <= wb_dat_i[15:8];
			// A zero length is prohibited, so such a write is ignored.
			if (sel_len && wb_sel_i[1:0] == 2'h3 && wb_dat_i[11:0] != 12'h000)
				bytes_per_block_reg <= wb_dat_i[11:0]; // see RULE7
			if (sel_cnt && wb_sel_i[0])
				block_total_reg[7:0] <= wb_dat_i[7:0];
			if (sel_cnt && wb_sel_i[1])
				block_total_reg[15:8] <= wb_dat_i[15:8];
			if (sel_msk && wb_sel_i[0])
				interrupt_enable_mask_reg <= wb_dat_i[`CTB_STATUS_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rsp_wait_reg <= 1'b0;
			rsp_cnt_reg  <= 8'h00;
		end else if (rsp_start) begin
			rsp_wait_reg <= 1'b1; // see RULE15
			rsp_cnt_reg  <= 8'h00;
		end else if (rsp_arr || rsp_expire) begin
			rsp_wait_reg <= 1'b0; // see RULE15
		end else if (rsp_wait_reg) begin
			rsp_cnt_reg <= rsp_cnt_reg + 8'h01; // see RULE1
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			data_wait_reg <= 1'b0;
			data_cnt_reg  <= 21'h000000;
		end else if (d_start) begin
			data_wait_reg <= 1'b1; // see RULE15
			data_cnt_reg  <= 21'h000000;
		end else if (d_arr || data_expire) begin
			data_wait_reg <= 1'b0;
		end else if (data_wait_reg) begin
			data_cnt_reg <= data_cnt_reg + 21'h000001; // see RULE6
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			xfer_state_reg <= CTB_IDLE;
			block_remaining_count_reg <= 16'h0000;
		end else begin
			case (xfer_state_reg)
				CTB_IDLE: begin
					if (x_start) begin
						xfer_state_reg <= CTB_XFER;
						block_remaining_count_reg <= block_total_reg; // see RULE14
					end
				end
				CTB_XFER: begin
					if (last_blk || stop_cmd)
						xfer_state_reg <= CTB_IDLE; // see RULE9
					if (blk_done && block_total_reg != 16'h0000)
						block_remaining_count_reg <= block_remaining_count_reg - 16'h0001;
				end
				default: xfer_state_reg <= CTB_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			primary_status_reg <= '0;
			irq_pend_reg <= 1'b0;
			irq_o <= 1'b0;
			xfer_active_o <= 1'b0;
		end else begin
			primary_status_reg <= primary_status_next; // see RULE1
			// Only a fresh unmasked rise arms the line; a read of status drops it.
			if (|(rising & interrupt_enable_mask_reg))
				irq_pend_reg <= 1'b1; // see RULE13
			else if (st_rd || !(|(primary_status_reg & interrupt_enable_mask_reg)))
				irq_pend_reg <= 1'b0;
			irq_o <= |(rising & interrupt_enable_mask_reg)
				|| (irq_pend_reg && !st_rd
				&& |(primary_status_reg & interrupt_enable_mask_reg)); // see RULE2
			xfer_active_o <= in_xfer;
		end
	end

	chk_rsp_timeout_flag: assert property (@(posedge clk) disable iff (!resetn) // see RULE1
		rsp_expire |=> primary_status_reg[`CTB_BIT_RSP_TO])
		else $error("response time-out flag not set");
	chk_rsp_irq_raise: assert property (@(posedge clk) disable iff (!resetn) // see RULE2
		(rsp_expire && interrupt_enable_mask_reg[`CTB_BIT_RSP_TO]) |=> irq_o)
		else $error("response time-out interrupt missing");
	chk_rsp_zero_off: assert property (@(posedge clk) disable iff (!resetn) // see RULE3
		response_limit_reg == 8'h00 |-> !rsp_expire)
		else $error("response timer ran with zero limit");
	chk_rsp_exact_len: assert property (@(posedge clk) disable iff (!resetn) // see RULE3
		(rsp_start && response_limit_reg == 8'h03)
		##1 (!rsp_arr && !rsp_start)[*3] |-> rsp_expire)
		else $error("response limit length wrong");
	chk_data_zero_off: assert property (@(posedge clk) disable iff (!resetn) // see RULE5
		data_limit == 21'h000000 |-> !data_expire)
		else $error("data timer ran with zero limit");
	chk_data_timeout_flag: assert property (@(posedge clk) disable iff (!resetn) // see RULE6
		data_expire |=> primary_status_reg[`CTB_BIT_DATA_TO])
		else $error("data time-out flag not set");
	chk_blk_len_nonzero: assert property (@(posedge clk) disable iff (!resetn) // see RULE7
		bytes_per_block_reg != 12'h000)
		else $error("block length became zero");
	chk_blk_load: assert property (@(posedge clk) disable iff (!resetn) // see RULE14
		(x_start && !in_xfer) |=> block_remaining_count_reg == $past(block_total_reg))
		else $error("remaining count not loaded");
	chk_blk_last_stop: assert property (@(posedge clk) disable iff (!resetn) // see RULE10
		last_blk |=> !in_xfer && block_remaining_count_reg == 16'h0000)
		else $error("transfer did not stop after last block");
	chk_infinite_run: assert property (@(posedge clk) disable iff (!resetn) // see RULE9
		(in_xfer && block_total_reg == 16'h0000 && !stop_cmd) |=> in_xfer)
		else $error("unlimited transfer stopped without stop");
	chk_irq_masked: assert property (@(posedge clk) disable iff (!resetn) // see RULE13
		(interrupt_enable_mask_reg == '0 && $past(interrupt_enable_mask_reg) == '0) |-> !irq_o)
		else $error("interrupt with all masks clear");

	chk_rsp_cnt_step: assert property (@(posedge clk) disable iff (!resetn) // see RULE1
		(rsp_wait_reg && !rsp_start && !rsp_arr && !rsp_expire)
		|=> rsp_cnt_reg == $past(rsp_cnt_reg) + 8'h01)
		else $error("response counter did not advance");

	chk_rsp_restart: assert property (@(posedge clk) disable iff (!resetn) // see RULE15
		rsp_start |=> rsp_wait_reg && rsp_cnt_reg == 8'h00)
		else $error("response wait did not restart");

	chk_rsp_arrive_stop: assert property (@(posedge clk) disable iff (!resetn) // see RULE15
		(rsp_arr && !rsp_start) |=> !rsp_wait_reg)
		else $error("response wait kept running after arrival");

	chk_data_restart: assert property (@(posedge clk) disable iff (!resetn) // see RULE15
		d_start |=> data_wait_reg && data_cnt_reg == 21'h000000)
		else $error("data wait did not restart");

	chk_data_arrive_stop: assert property (@(posedge clk) disable iff (!resetn) // see RULE15
		(d_arr && !d_start) |=> !data_wait_reg)
		else $error("data wait kept running after arrival");

	chk_data_cnt_step: assert property (@(posedge clk) disable iff (!resetn) // see RULE6
		(data_wait_reg && !d_start && !d_arr && !data_expire)
		|=> data_cnt_reg == $past(data_cnt_reg) + 21'h000001)
		else $error("data counter did not advance");

	chk_data_exact_len: assert property (@(posedge clk) disable iff (!resetn) // see RULE5
		(d_start && data_limit == 21'h000008)
		##1 (!d_arr && !d_start)[*8] |-> data_expire)
		else $error("data limit length wrong");

	chk_data_irq_raise: assert property (@(posedge clk) disable iff (!resetn) // see RULE6
		(data_expire && interrupt_enable_mask_reg[`CTB_BIT_DATA_TO]) |=> irq_o)
		else $error("data time-out interrupt missing");

	chk_rsp_flag_sticky: assert property (@(posedge clk) disable iff (!resetn) // see RULE1
		(primary_status_reg[`CTB_BIT_RSP_TO] && !st_rd) |=> primary_status_reg[`CTB_BIT_RSP_TO])
		else $error("response time-out flag lost");

	chk_status_clear: assert property (@(posedge clk) disable iff (!resetn) // see RULE1
		(st_rd && !(|events)) |=> primary_status_reg == '0)
		else $error("status not cleared by read");

	chk_irq_needs_flag: assert property (@(posedge clk) disable iff (!resetn) // see RULE13
		irq_o |-> $past(|(primary_status_next & interrupt_enable_mask_reg)))
		else $error("interrupt without unmasked flag");

	chk_irq_rise_event: assert property (@(posedge clk) disable iff (!resetn) // see RULE13
		$rose(irq_o) |-> $past(|(events & interrupt_enable_mask_reg)))
		else $error("interrupt rose without unmasked event");

	chk_blk_count_down: assert property (@(posedge clk) disable iff (!resetn) // see RULE14
		(blk_done && in_xfer && block_total_reg != 16'h0000)
		|=> block_remaining_count_reg == $past(block_remaining_count_reg) - 16'h0001)
		else $error("remaining count did not drop");

	chk_open_rem_zero: assert property (@(posedge clk) disable iff (!resetn) // see RULE9
		(in_xfer && block_total_reg == 16'h0000 && block_remaining_count_reg == 16'h0000)
		|=> block_remaining_count_reg == 16'h0000)
		else $error("open transfer moved remaining count");

	chk_stop_ends: assert property (@(posedge clk) disable iff (!resetn) // see RULE9
		(stop_cmd && in_xfer) |=> !in_xfer)
		else $error("stop did not end transfer");

	chk_done_flag: assert property (@(posedge clk) disable iff (!resetn) // see RULE10
		last_blk |=> primary_status_reg[`CTB_BIT_DONE])
		else $error("transfer done flag not set");

	chk_idle_rem_hold: assert property (@(posedge clk) disable iff (!resetn) // see RULE14
		(!in_xfer && !x_start) |=> block_remaining_count_reg == $past(block_remaining_count_reg))
		else $error("remaining count moved while idle");

	chk_xfer_out_follow: assert property (@(posedge clk) disable iff (!resetn) // see RULE10
		xfer_active_o == $past(in_xfer))
		else $error("transfer active output out of step");

	chk_len_zero_hold: assert property (@(posedge clk) disable iff (!resetn) // see RULE7
		(wr && sel_len && wb_dat_i[11:0] == 12'h000)
		|=> bytes_per_block_reg == $past(bytes_per_block_reg))
		else $error("zero block length accepted");

	chk_rto_read: assert property (@(posedge clk) disable iff (!resetn) // see RULE4
		(rd && sel_rto)
		|=> wb_dat_o == {19'h0, $past(data_limit_upper_reg), $past(response_limit_reg)})
		else $error("response time-out read wrong");

	chk_dto_read: assert property (@(posedge clk) disable iff (!resetn) // see RULE4
		(rd && sel_dto) |=> wb_dat_o == {16'h0, $past(data_limit_lower_reg)})
		else $error("data time-out read wrong");

	chk_rem_read: assert property (@(posedge clk) disable iff (!resetn) // see RULE11
		(rd && sel_rem) |=> wb_dat_o == {16'h0, $past(block_remaining_count_reg)})
		else $error("remaining count read wrong");

	chk_len_read: assert property (@(posedge clk) disable iff (!resetn) // see RULE7
		(rd && sel_len) |=> wb_dat_o == {20'h0, $past(bytes_per_block_reg)})
		else $error("block length read wrong");

	chk_cnt_read: assert property (@(posedge clk) disable iff (!resetn) // see RULE10
		(rd && sel_cnt) |=> wb_dat_o == {16'h0, $past(block_total_reg)})
		else $error("block total read wrong");

	chk_status_read: assert property (@(posedge clk) disable iff (!resetn) // see RULE1
		(rd && sel_st) |=> wb_dat_o == {27'h0, $past(primary_status_reg)})
		else $error("status read wrong");

	chk_ack_pulse: assert property (@(posedge clk) disable iff (!resetn) // see RULE11
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");

	chk_ack_follows: assert property (@(posedge clk) disable iff (!resetn) // see RULE11
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("request not acknowledged");

	chk_dat_idle_zero: assert property (@(posedge clk) disable iff (!resetn) // see RULE11
		!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
endmodule

// *** verification/ctb_card_model.sv ***
`timescale 1ns/10ps
module ctb_card_model #(
	parameter logic [11:0] CARD_BLOCK = 12'h080
) (
	input  wire logic       clk,
	input  wire logic       start,
	input  wire logic [7:0] delay,
	output logic            answered
);
	// A delay of 0 stands for a silent card, the only fault the bench asks for.
	logic [7:0] left_reg;
	initial begin
		left_reg = 8'h00;
		answered = 1'b0;
	end
	always @(posedge clk) begin
		answered <= (left_reg == 8'h01);
		if (start)
			left_reg <= delay;
		else if (left_reg != 8'h00)
			left_reg <= left_reg - 8'h01;
	end
endmodule

// *** verification/tb.sv ***
`timescale 1ns/10ps
`include "ctb_consts.svh"
module tb;
	logic        clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, xfer_active_o;
	logic        card_go, card_ans;
	logic [3:0]  wb_sel_i;
	logic [7:0]  wb_adr_i, dly;
	logic [31:0] wb_dat_i, wb_dat_o, rd, lf;
	int          failures, num_checks, cyc_cnt, n, k;

	ctb_timeout_block_count dut (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
		.xfer_active_o(xfer_active_o));
	ctb_card_model card (.clk(clk), .start(card_go), .delay(dly), .answered(card_ans));

	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			failures++;
			end_of_test;
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Ack is sampled at the edge, so the request is released only after it was seen.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	task automatic ctrl(input int b);
		bus(1'b1, `CTB_ADDR_CTRL, 32'h1 << b);
	endtask

	// Response wait; the card answers after ans cycles, or never when ans is 0.
	task automatic rsp_case(input logic [7:0] lim, input logic [7:0] ans);
		bus(1'b1, `CTB_ADDR_RSP_TO, {24'h0, lim});
		dly <= ans;
		ctrl(`CTB_CTRL_RSP_START);
		card_go <= 1'b1;
		n = 0;
		while (irq_o !== 1'b1 && card_ans !== 1'b1 && n < 300) begin
			@(posedge clk);
			card_go <= 1'b0;
			n++;
		end
		if (card_ans === 1'b1)
			ctrl(`CTB_CTRL_RSP_ARRIVE);
		repeat (lim + 4) @(posedge clk);
		if (lim != 0 && ans == 0)
			chk(n, lim);
		rchk(`CTB_ADDR_STATUS, (lim != 0 && ans == 0) ? 32'h10 : 32'h0);
		repeat (2) @(posedge clk);
		chk(irq_o, 1'b0);
	endtask

	initial begin
		{clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, card_go} = 6'h00;
		{wb_adr_i, dly, wb_dat_i} = 48'h0;
		wb_sel_i = 4'hF;
		{failures, num_checks, cyc_cnt} = 0;
		lf = 32'd77637;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		rchk(`CTB_ADDR_BLK_LEN, 32'h200);
		bus(1'b1, `CTB_ADDR_BLK_LEN, 32'h0);
		rchk(`CTB_ADDR_BLK_LEN, 32'h200);
		bus(1'b1, `CTB_ADDR_BLK_LEN, {20'h0, card.CARD_BLOCK});
		rchk(`CTB_ADDR_BLK_LEN, {20'h0, card.CARD_BLOCK});
		rchk(8'h40, 32'h0);
		$display("test registers done");
		bus(1'b1, `CTB_ADDR_MASK, 32'h0);
		bus(1'b1, `CTB_ADDR_RSP_TO, 32'h5);
		ctrl(`CTB_CTRL_RSP_START);
		repeat (20) @(posedge clk);
		chk(irq_o, 1'b0);
		rchk(`CTB_ADDR_STATUS, 32'h10);
		bus(1'b1, `CTB_ADDR_MASK, 32'h18);
		for (int i = 0; i < 6; i++) begin
			lf = lfsr(lf);
			rsp_case(8'd32 + lf[4:0], i[0] ? 8'd8 + lf[4:1] : 8'd0);
		end
		rsp_case(8'd3, 8'd0);
		rsp_case(8'd0, 8'd0);
		$display("test response wait done");
		bus(1'b1, `CTB_ADDR_RSP_TO, 32'hFFFF_FFFF);
		rchk(`CTB_ADDR_RSP_TO, 32'h1FFF);
		bus(1'b1, `CTB_ADDR_RSP_TO, 32'h0);
		bus(1'b1, `CTB_ADDR_DATA_TO, 32'hFFFF_0008);
		rchk(`CTB_ADDR_DATA_TO, 32'h8);
		ctrl(`CTB_CTRL_DATA_START);
		for (n = 0; irq_o !== 1'b1 && n < 300; n++)
			@(posedge clk);
		chk(n, 8);
		rchk(`CTB_ADDR_STATUS, 32'h8);
		$display("test data wait done");
		lf = lfsr(lf);
		k = 2 + lf[1:0];
		bus(1'b1, `CTB_ADDR_BLK_CNT, k);
		ctrl(`CTB_CTRL_XFER_START);
		rchk(`CTB_ADDR_BLK_REM, k);
		chk(xfer_active_o, 1'b1);
		for (int i = 1; i <= k; i++) begin
			ctrl(`CTB_CTRL_BLK_DONE);
			rchk(`CTB_ADDR_BLK_REM, k - i);
		end
		chk(xfer_active_o, 1'b0);
		rchk(`CTB_ADDR_STATUS, 32'h1);
		$display("test counted blocks done");
		bus(1'b1, `CTB_ADDR_BLK_CNT, 32'h0);
		ctrl(`CTB_CTRL_XFER_START);
		repeat (5) ctrl(`CTB_CTRL_BLK_DONE);
		rchk(`CTB_ADDR_BLK_REM, 32'h0);
		chk(xfer_active_o, 1'b1);
		ctrl(`CTB_CTRL_STOP);
		repeat (2) @(posedge clk);
		chk(xfer_active_o, 1'b0);
		rchk(`CTB_ADDR_STATUS, 32'h1);
		$display("test open blocks done");
		end_of_test;
	end
endmodule
